// ===== src/mrs_defs.svh
// Constants for the memory request scheduler
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH
`define MRS_RQ_DEPTH 31
`define MRS_RQ_HI 27
`define MRS_RQ_LO 20
`define MRS_ROQ_NUM 4
`define MRS_WPB_DEPTH 64
`define MRS_WPB_HI 60
`define MRS_WPB_LO 56
`define MRS_COPY_GAP 8
`define MRS_BURST_MIN 4
`define MRS_CLK_NS 100
`define MRS_RW_GAP_NS 200
`define MRS_RW_GAP_CYC ((`MRS_RW_GAP_NS + `MRS_CLK_NS - 1) / `MRS_CLK_NS)
`define MRS_CHAN0_BIT 1
`define MRS_BANK0_BIT 2
`define MRS_BANK1_BIT 3
`define MRS_WAY_W 4
`endif

// ===== src/mrs_pkg.sv
// Types for the memory request scheduler
package mrs_pkg;
	typedef enum logic [1:0] {MRS_SRC_PB, MRS_SRC_REM, MRS_SRC_LOC} mrs_src_type;
	typedef enum {MRS_WB_IDLE, MRS_WB_BURST} mrs_burst_type;
endpackage

// ===== src/mrs_buf_if.sv
// Port bundle between scheduler and posted write data store
interface mrs_buf_if #(parameter int AW = 6, parameter int DW = 32);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_a_addr;
	logic [DW-1:0] rd_a_data;
	logic [AW-1:0] rd_b_addr;
	logic [DW-1:0] rd_b_data;
	modport ctrl (output wr_en, wr_addr, wr_data, rd_a_addr, rd_b_addr, input rd_a_data, rd_b_data);
	modport mem (input wr_en, wr_addr, wr_data, rd_a_addr, rd_b_addr, output rd_a_data, rd_b_data);
endinterface

// ===== src/mrs_buf_mem.sv
// Posted write data store, one write and two registered read ports
module mrs_buf_mem #(parameter int DEPTH = 64, parameter int DW = 32) (
	input wire logic sys_clk,
	mrs_buf_if.mem bus
);
	logic [DW-1:0] mem_reg [DEPTH];
	logic [DW-1:0] rd_a_reg;
	logic [DW-1:0] rd_b_reg;
	// Reads see old data on a same-cycle write; slots are never reused while read
	always_ff @(posedge sys_clk) begin
		if (bus.wr_en) begin
			mem_reg[bus.wr_addr] <= bus.wr_data;
		end
		rd_a_reg <= mem_reg[bus.rd_a_addr];
		rd_b_reg <= mem_reg[bus.rd_b_addr];
	end
	assign bus.rd_a_data = rd_a_reg;
	assign bus.rd_b_data = rd_b_reg;
endmodule // mrs_buf_mem

// ===== src/mrs_top.sv
// Memory request scheduler: arbitration, decode, queues, issue
`include "mrs_defs.svh"
module mrs_top #(
	parameter int ADDR_W = 16,
	parameter int TAG_W = 4,
	parameter int DATA_W = 32,
	parameter int NRANGE = 2,
	parameter int RQ_DEPTH = `MRS_RQ_DEPTH,
	parameter int WPB_DEPTH = `MRS_WPB_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [2:0] req_valid,
	input wire logic [2:0] req_write,
	input wire logic [2:0] req_partial,
	input wire logic [2:0] req_crit,
	input wire logic [ADDR_W-1:0] req_addr [3],
	input wire logic [TAG_W-1:0] req_tag [3],
	input wire logic [DATA_W-1:0] req_data [3],
	output logic [2:0] req_ready,
	output logic pb_retry,
	input wire logic [ADDR_W-1:0] range_base [NRANGE],
	input wire logic [ADDR_W-1:0] range_limit [NRANGE],
	input wire logic [`MRS_WAY_W-1:0] interleave_way_field [NRANGE],
	input wire logic min_write_burst_enable,
	input wire logic err_clear,
	input wire logic cancel_valid,
	input wire logic [TAG_W-1:0] cancel_tag,
	input wire logic [3:0] res_conflict,
	input wire logic mem_cmd_ready,
	input wire logic mem_rsp_valid,
	input wire logic [TAG_W-1:0] mem_rsp_tag,
	input wire logic [DATA_W-1:0] mem_rsp_data,
	input wire logic merge_done,
	input wire logic [DATA_W-1:0] merge_data,
	output logic merge_done_ack,
	output logic merge_req_valid,
	output logic [ADDR_W-1:0] merge_req_addr,
	output logic priority_bus_request_pin_n,
	output logic block_next_request_pin_n,
	output logic first_error_status_illegal,
	output logic miss_notify,
	output logic read_drop,
	output logic fwd_valid,
	output logic [TAG_W-1:0] fwd_tag,
	output logic [DATA_W-1:0] fwd_data,
	output logic mem_cmd_valid,
	output logic mem_cmd_write,
	output logic mem_cmd_crit_first,
	output logic [ADDR_W-1:0] mem_cmd_addr,
	output logic [TAG_W-1:0] mem_cmd_tag,
	output logic [DATA_W-1:0] mem_cmd_data,
	output logic rd_rsp_valid,
	output logic [TAG_W-1:0] rd_rsp_tag,
	output logic [DATA_W-1:0] rd_rsp_data
);
	import mrs_pkg::*;
	localparam int RE_W = ADDR_W + TAG_W + 1;
	localparam int PW = $clog2(WPB_DEPTH);
	localparam int RPW = $clog2(RQ_DEPTH);
	localparam int RCW = $clog2(RQ_DEPTH + 1);
	localparam int WCW = $clog2(WPB_DEPTH + 1);
	localparam int NT = 2 ** TAG_W;

	function automatic logic in_range(input logic [ADDR_W-1:0] a);
		in_range = 1'b0;
		for (int i = 0; i < NRANGE; i++) begin
			if (interleave_way_field[i] != '0 && a >= range_base[i] && a <= range_limit[i]) begin
				in_range = 1'b1;
			end
		end
	endfunction

	function automatic logic [1:0] roq_index(input logic [ADDR_W-1:0] a);
		logic all_way;
		all_way = 1'b0;
		for (int i = 0; i < NRANGE; i++) begin
			if (a >= range_base[i] && a <= range_limit[i] && (&interleave_way_field[i])) begin
				all_way = 1'b1;
			end
		end
		roq_index = {a[`MRS_BANK0_BIT], all_way ? a[`MRS_BANK1_BIT] : a[`MRS_CHAN0_BIT]};
	endfunction

	// Round-robin pick: {found, queue}
	function automatic logic [2:0] rr_pick(input logic [3:0] elig, input logic [1:0] ptr);
		logic [1:0] q;
		rr_pick = 3'h0;
		for (int k = 3; k >= 0; k--) begin
			q = ptr + 2'(k);
			if (elig[q]) begin
				rr_pick = {1'b1, q};
			end
		end
	endfunction

	function automatic logic [RPW-1:0] rq_inc(input logic [RPW-1:0] p);
		rq_inc = (p == RPW'(RQ_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// State
	logic rr_reg, rq_throttle_reg, bnr_reg, illegal_reg, miss_reg, drop_reg;
	logic [3:0] copy_cnt_reg;
	logic [1:0] gap_cnt_reg;
	logic [NT-1:0] kill_reg;
	logic [RE_W-1:0] rq_mem_reg [RQ_DEPTH];
	logic [RPW-1:0] rq_head_reg, rq_tail_reg;
	logic [RCW-1:0] rq_count_reg;
	logic [RE_W-1:0] rroq_reg [4][2];
	logic [1:0] rroq_cnt_reg [4];
	logic [PW-1:0] wroq_reg [4][2];
	logic [1:0] wroq_cnt_reg [4];
	logic [1:0] rptr_reg, wptr_reg;
	logic [WPB_DEPTH-1:0] wv_reg;
	logic [ADDR_W-1:0] waddr_reg [WPB_DEPTH];
	logic [PW-1:0] tail_reg, disp_reg;
	logic [WCW-1:0] wcnt_reg, wpend_reg;
	mrs_burst_type burst_reg, burst_next;
	logic merge_busy_reg, merge_req_reg;
	logic [ADDR_W-1:0] merge_addr_reg;
	logic fwd_valid_reg, cmd_valid_reg, cmd_write_reg, cmd_crit_reg, rsp_valid_reg;
	logic [TAG_W-1:0] fwd_tag_reg, cmd_tag_reg, rsp_tag_reg;
	logic [ADDR_W-1:0] cmd_addr_reg;
	logic [DATA_W-1:0] rsp_data_reg;

	mrs_buf_if #(.AW(PW), .DW(DATA_W)) wbuf ();
	mrs_buf_mem #(.DEPTH(WPB_DEPTH), .DW(DATA_W)) u_wbuf (
		.sys_clk(sys_clk),
		.bus(wbuf.mem)
	);

	// Arbitration
	wire rem_ok = req_valid[1] & ~rq_throttle_reg;
	wire loc_ok = req_valid[2];
	wire sel_valid = req_valid[0] | rem_ok | loc_ok;
	wire mrs_src_type sel_src = req_valid[0] ? MRS_SRC_PB :
		(rem_ok && (!loc_ok || !rr_reg)) ? MRS_SRC_REM : MRS_SRC_LOC;
	wire [1:0] sel_idx = sel_src;
	wire s_write = req_write[sel_idx];
	wire s_partial = req_partial[sel_idx];
	wire [ADDR_W-1:0] s_addr = req_addr[sel_idx];
	wire [TAG_W-1:0] s_tag = req_tag[sel_idx];
	wire s_hit = in_range(s_addr);
	wire s_retry = (sel_src == MRS_SRC_PB) && merge_busy_reg && s_addr == merge_addr_reg;

	// Youngest matching posted write, oldest scanned first so younger overwrite
	logic fwd_hit;
	logic [PW-1:0] fwd_slot;
	always_comb begin
		fwd_hit = 1'b0;
		fwd_slot = '0;
		for (int k = WPB_DEPTH; k >= 1; k--) begin
			if (wv_reg[tail_reg - PW'(k)] && waddr_reg[tail_reg - PW'(k)] == s_addr) begin
				fwd_hit = 1'b1;
				fwd_slot = tail_reg - PW'(k);
			end
		end
	end

	// Read- and write-side acceptance conditions
	wire copy_idle = copy_cnt_reg == 4'h0;
	wire roq_empty = rroq_cnt_reg[0] == 2'd0 && rroq_cnt_reg[1] == 2'd0 &&
		rroq_cnt_reg[2] == 2'd0 && rroq_cnt_reg[3] == 2'd0;
	wire imm_ok = ~fwd_hit & (rq_count_reg == '0) & roq_empty & mem_cmd_ready;
	wire rd_cond = fwd_hit ? copy_idle : (imm_ok | rq_count_reg < RCW'(RQ_DEPTH));
	wire slot_free = ~wv_reg[tail_reg];
	wire merge_post = merge_busy_reg & merge_done & slot_free;
	wire wr_cond = s_partial ? ~merge_busy_reg : (slot_free & ~merge_post);
	wire s_cond = s_retry | ~s_hit | (s_write ? wr_cond : rd_cond);
	// Posting buffer at its high mark (MRS_WPB_HI) blocks everything, reads included
	wire acc = sel_valid & ~bnr_reg & s_cond;
	wire acc_new = acc & ~s_retry & s_hit;
	wire acc_rd = acc_new & ~s_write;
	wire rd_fwd = acc_rd & fwd_hit;
	wire rd_imm = acc_rd & imm_ok;
	wire rd_push = acc_rd & ~fwd_hit & ~imm_ok;
	wire wr_post = acc_new & s_write & ~s_partial;
	wire part_start = acc_new & s_write & s_partial;
	assign req_ready = acc ? (3'h1 << sel_idx) : 3'h0;
	assign pb_retry = acc & s_retry;

	// Read queue head moves to its re-ordering queue
	wire [RE_W-1:0] rq_head = rq_mem_reg[rq_head_reg];
	wire rq_head_kill = kill_reg[rq_head[ADDR_W +: TAG_W]];
	wire [1:0] rq_qi = roq_index(rq_head[ADDR_W-1:0]);
	wire rq_move = (rq_count_reg != '0) & (rq_head_kill | rroq_cnt_reg[rq_qi] != 2'd2);
	logic [3:0] rd_elig, wr_elig;
	always_comb begin
		for (int q = 0; q < 4; q++) begin
			rd_elig[q] = rroq_cnt_reg[q] != 2'd0 &
				(~res_conflict[q] | kill_reg[rroq_reg[q][0][ADDR_W +: TAG_W]]);
			wr_elig[q] = wroq_cnt_reg[q] != 2'd0 & ~res_conflict[q];
		end
	end
	wire [2:0] rsel = rr_pick(rd_elig, rptr_reg);
	wire [RE_W-1:0] rhead = rroq_reg[rsel[1:0]][0];
	wire rhead_kill = kill_reg[rhead[ADDR_W +: TAG_W]];
	wire rd_pop = rsel[2] & ~rd_imm & (mem_cmd_ready | rhead_kill);
	wire rd_issue = rd_pop & ~rhead_kill;
	wire rd_ready = rsel[2] | rd_imm;

	// Write dispatch and issue
	wire [1:0] wd_qi = roq_index(waddr_reg[disp_reg]);
	wire w_move = (wpend_reg != '0) & (wroq_cnt_reg[wd_qi] != 2'd2);
	wire [2:0] wsel = rr_pick(wr_elig, wptr_reg);
	wire [PW-1:0] wslot = wroq_reg[wsel[1:0]][0];
	wire burst_start = (burst_reg == MRS_WB_IDLE) & ~rd_ready & (gap_cnt_reg == 2'd0) &
		(wcnt_reg >= WCW'(`MRS_BURST_MIN));
	wire wr_mode = ~min_write_burst_enable | burst_reg == MRS_WB_BURST | burst_start;
	// Data is written with the post, so a queued write always has it
	wire wr_go = wsel[2] & ~rd_ready & mem_cmd_ready & wr_mode;
	wire [WCW-1:0] wcnt_next = wcnt_reg + WCW'(wr_post | merge_post) - WCW'(wr_go);

	always_comb begin
		burst_next = burst_reg;
		unique case (burst_reg)
			MRS_WB_IDLE: begin
				if (burst_start & min_write_burst_enable) begin
					burst_next = MRS_WB_BURST;
				end
			end
			MRS_WB_BURST: begin
				if (~min_write_burst_enable | acc_rd | wcnt_next == '0) begin
					burst_next = MRS_WB_IDLE;
				end
			end
		endcase
	end

	assign wbuf.ctrl.wr_en = wr_post | merge_post;
	assign wbuf.ctrl.wr_addr = tail_reg;
	assign wbuf.ctrl.wr_data = merge_post ? merge_data : req_data[sel_idx];
	assign wbuf.ctrl.rd_a_addr = fwd_slot;
	assign wbuf.ctrl.rd_b_addr = wslot;
	assign merge_done_ack = merge_post;

	// Control state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rr_reg <= 1'b0;
			rq_throttle_reg <= 1'b0;
			bnr_reg <= 1'b0;
			illegal_reg <= 1'b0;
			miss_reg <= 1'b0;
			drop_reg <= 1'b0;
			copy_cnt_reg <= 4'h0;
			gap_cnt_reg <= 2'd0;
			kill_reg <= '0;
			burst_reg <= MRS_WB_IDLE;
			merge_busy_reg <= 1'b0;
			merge_req_reg <= 1'b0;
		end else begin
			if (acc & sel_src != MRS_SRC_PB) begin
				rr_reg <= (sel_src == MRS_SRC_REM);
			end
			if (rq_count_reg >= RCW'(`MRS_RQ_HI)) begin
				rq_throttle_reg <= 1'b1;
			end else if (rq_count_reg <= RCW'(`MRS_RQ_LO)) begin
				rq_throttle_reg <= 1'b0;
			end
			if (wcnt_reg >= WCW'(`MRS_WPB_HI)) begin
				bnr_reg <= 1'b1;
			end else if (wcnt_reg < WCW'(`MRS_WPB_LO)) begin
				bnr_reg <= 1'b0;
			end
			// Set wins over clear
			if (acc & s_write & ~s_hit & sel_src == MRS_SRC_REM) begin
				illegal_reg <= 1'b1;
			end else if (err_clear) begin
				illegal_reg <= 1'b0;
			end
			miss_reg <= acc & s_write & ~s_hit & sel_src == MRS_SRC_PB;
			drop_reg <= acc & ~s_write & ~s_hit & ~s_retry;
			copy_cnt_reg <= rd_fwd ? 4'(`MRS_COPY_GAP - 1) : (copy_idle ? 4'h0 : copy_cnt_reg - 4'h1);
			gap_cnt_reg <= (rd_imm | rd_issue) ? 2'(`MRS_RW_GAP_CYC) :
				(gap_cnt_reg == 2'd0 ? 2'd0 : gap_cnt_reg - 2'd1);
			for (int t = 0; t < NT; t++) begin
				if (cancel_valid && cancel_tag == TAG_W'(t)) begin
					kill_reg[t] <= 1'b1;
				end else if (acc_rd && s_tag == TAG_W'(t)) begin
					kill_reg[t] <= 1'b0;
				end
			end
			burst_reg <= burst_next;
			if (part_start) begin
				merge_busy_reg <= 1'b1;
			end else if (merge_post) begin
				merge_busy_reg <= 1'b0;
			end
			merge_req_reg <= part_start;
		end
	end

	// Queue pointers and counts
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rq_head_reg <= '0;
			rq_tail_reg <= '0;
			rq_count_reg <= '0;
			rptr_reg <= 2'd0;
			wptr_reg <= 2'd0;
			wv_reg <= '0;
			tail_reg <= '0;
			disp_reg <= '0;
			wcnt_reg <= '0;
			wpend_reg <= '0;
			for (int q = 0; q < 4; q++) begin
				rroq_cnt_reg[q] <= 2'd0;
				wroq_cnt_reg[q] <= 2'd0;
			end
		end else begin
			if (rd_push) begin
				rq_tail_reg <= rq_inc(rq_tail_reg);
			end
			if (rq_move) begin
				rq_head_reg <= rq_inc(rq_head_reg);
			end
			rq_count_reg <= rq_count_reg + RCW'(rd_push) - RCW'(rq_move);
			if (rd_pop) begin
				rptr_reg <= rsel[1:0] + 2'd1;
			end
			if (wr_go) begin
				wptr_reg <= wsel[1:0] + 2'd1;
				wv_reg[wslot] <= 1'b0;
			end
			if (wr_post | merge_post) begin
				wv_reg[tail_reg] <= 1'b1;
				tail_reg <= tail_reg + 1'b1;
			end
			if (w_move) begin
				disp_reg <= disp_reg + 1'b1;
			end
			wcnt_reg <= wcnt_next;
			wpend_reg <= wpend_reg + WCW'(wr_post | merge_post) - WCW'(w_move);
			for (int q = 0; q < 4; q++) begin
				rroq_cnt_reg[q] <= rroq_cnt_reg[q] + 2'(rq_move & ~rq_head_kill & rq_qi == 2'(q)) -
					2'(rd_pop & rsel[1:0] == 2'(q));
				wroq_cnt_reg[q] <= wroq_cnt_reg[q] + 2'(w_move & wd_qi == 2'(q)) -
					2'(wr_go & wsel[1:0] == 2'(q));
			end
		end
	end

	// Queue contents, no reset needed behind the counts
	always_ff @(posedge sys_clk) begin
		if (rd_push) begin
			rq_mem_reg[rq_tail_reg] <= {req_crit[sel_idx], s_tag, s_addr};
		end
		if (wr_post | merge_post) begin
			waddr_reg[tail_reg] <= merge_post ? merge_addr_reg : s_addr;
		end
		if (part_start) begin
			merge_addr_reg <= s_addr;
		end
		for (int q = 0; q < 4; q++) begin
			if (rd_pop & rsel[1:0] == 2'(q)) begin
				rroq_reg[q][0] <= rroq_reg[q][1];
			end
			if (rq_move & ~rq_head_kill & rq_qi == 2'(q)) begin
				rroq_reg[q][rroq_cnt_reg[q] == 2'd1 && !(rd_pop & rsel[1:0] == 2'(q))] <= rq_head;
			end
			if (wr_go & wsel[1:0] == 2'(q)) begin
				wroq_reg[q][0] <= wroq_reg[q][1];
			end
			if (w_move & wd_qi == 2'(q)) begin
				wroq_reg[q][wroq_cnt_reg[q] == 2'd1 && !(wr_go & wsel[1:0] == 2'(q))] <= disp_reg;
			end
		end
	end

	// Command and answer registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fwd_valid_reg <= 1'b0;
			cmd_valid_reg <= 1'b0;
			rsp_valid_reg <= 1'b0;
			fwd_tag_reg <= '0;
			cmd_write_reg <= 1'b0;
			cmd_crit_reg <= 1'b0;
			cmd_tag_reg <= '0;
			cmd_addr_reg <= '0;
			rsp_tag_reg <= '0;
			rsp_data_reg <= '0;
		end else begin
			fwd_valid_reg <= rd_fwd;
			fwd_tag_reg <= s_tag;
			cmd_valid_reg <= rd_imm | rd_issue | wr_go;
			cmd_write_reg <= ~rd_imm & ~rd_issue;
			cmd_crit_reg <= rd_imm ? req_crit[sel_idx] : (rd_issue & rhead[RE_W-1]);
			cmd_tag_reg <= rd_imm ? s_tag : rhead[ADDR_W +: TAG_W];
			cmd_addr_reg <= rd_imm ? s_addr : (rd_issue ? rhead[ADDR_W-1:0] : waddr_reg[wslot]);
			rsp_valid_reg <= mem_rsp_valid & ~kill_reg[mem_rsp_tag];
			rsp_tag_reg <= mem_rsp_tag;
			rsp_data_reg <= mem_rsp_data;
		end
	end

	assign priority_bus_request_pin_n = ~rq_throttle_reg;
	assign block_next_request_pin_n = ~bnr_reg;
	assign first_error_status_illegal = illegal_reg;
	assign miss_notify = miss_reg;
	assign read_drop = drop_reg;
	assign merge_req_valid = merge_req_reg;
	assign merge_req_addr = merge_addr_reg;
	assign fwd_valid = fwd_valid_reg;
	assign fwd_tag = fwd_tag_reg;
	assign fwd_data = wbuf.ctrl.rd_a_data;
	assign mem_cmd_valid = cmd_valid_reg;
	assign mem_cmd_write = cmd_write_reg;
	assign mem_cmd_crit_first = cmd_crit_reg;
	assign mem_cmd_addr = cmd_addr_reg;
	assign mem_cmd_tag = cmd_tag_reg;
	assign mem_cmd_data = wbuf.ctrl.rd_b_data;
	assign rd_rsp_valid = rsp_valid_reg;
	assign rd_rsp_tag = rsp_tag_reg;
	assign rd_rsp_data = rsp_data_reg;

	// Checks
	property p_copy_gap;
		@(posedge sys_clk) disable iff (!rst_n) rd_fwd |=> !rd_fwd [*7];
	endproperty
	a_copy_gap: assert property (p_copy_gap) else $error("copy engine too fast");
	property p_pb_prio;
		@(posedge sys_clk) disable iff (!rst_n) req_valid[0] |-> req_ready[2:1] == 2'b00;
	endproperty
	a_pb_prio: assert property (p_pb_prio) else $error("queue granted over processor");
	sequence s_both_grant;
		!req_valid[0] && rem_ok && loc_ok && acc;
	endsequence
	property p_rr;
		@(posedge sys_clk) disable iff (!rst_n) s_both_grant ##1 s_both_grant |-> req_ready != $past(req_ready);
	endproperty
	a_rr: assert property (p_rr) else $error("no alternation");
	property p_miss_drop;
		@(posedge sys_clk) disable iff (!rst_n) (acc && !s_write && !s_hit && !s_retry) |=> read_drop && !fwd_valid;
	endproperty
	a_miss_drop: assert property (p_miss_drop) else $error("missed read not dropped");
	property p_imm;
		@(posedge sys_clk) disable iff (!rst_n)
			rd_imm |=> mem_cmd_valid && !mem_cmd_write && mem_cmd_addr == $past(s_addr);
	endproperty
	a_imm: assert property (p_imm) else $error("idle read not issued");
	property p_kill;
		@(posedge sys_clk) disable iff (!rst_n) (mem_rsp_valid && kill_reg[mem_rsp_tag]) |=> !rd_rsp_valid;
	endproperty
	a_kill: assert property (p_kill) else $error("cancelled data delivered");
	property p_rq_throttle;
		@(posedge sys_clk) disable iff (!rst_n)
			(rq_count_reg >= RCW'(`MRS_RQ_HI)) |=> !priority_bus_request_pin_n && !req_ready[1];
	endproperty
	a_rq_throttle: assert property (p_rq_throttle) else $error("read queue not throttled");
	property p_bnr;
		@(posedge sys_clk) disable iff (!rst_n)
			(wcnt_reg >= WCW'(`MRS_WPB_HI)) |=> !block_next_request_pin_n && req_ready == 3'h0;
	endproperty
	a_bnr: assert property (p_bnr) else $error("posting buffer not blocked");
	property p_wr_gate;
		@(posedge sys_clk) disable iff (!rst_n) wr_go |-> !rd_ready && !res_conflict[wsel[1:0]];
	endproperty
	a_wr_gate: assert property (p_wr_gate) else $error("write issued against read");
	property p_merge_one;
		@(posedge sys_clk) disable iff (!rst_n) merge_busy_reg |-> !part_start;
	endproperty
	a_merge_one: assert property (p_merge_one) else $error("second partial merge");
	c_fwd: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_fwd ##1 fwd_valid);
	c_burst: cover property (@(posedge sys_clk) disable iff (!rst_n) burst_reg == MRS_WB_BURST && wr_go);
	c_merge: cover property (@(posedge sys_clk) disable iff (!rst_n) part_start ##[1:20] merge_post);
	c_throttle: cover property (@(posedge sys_clk) disable iff (!rst_n) $fell(priority_bus_request_pin_n));
endmodule // mrs_top

// ===== dv/mrs_mem_model.sv
// Memory channel model: ready control and fixed latency read replies
module mrs_mem_model #(parameter int LAT = 4) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic mem_cmd_valid,
	input wire logic mem_cmd_write,
	input wire logic [3:0] mem_cmd_tag,
	output logic mem_cmd_ready,
	output logic mem_rsp_valid,
	output logic [3:0] mem_rsp_tag,
	output logic [31:0] mem_rsp_data
);
	logic [LAT-1:0] pend_reg;
	logic [3:0] tag_reg [LAT];
	logic [31:0] rsp_word;
	assign mem_cmd_ready = ~stall;
	assign mem_rsp_valid = pend_reg[LAT-1];
	assign rsp_word = {28'hD000000, tag_reg[LAT-1]};
	// Outside a reply the bus shows inverted values, never the last reply
	assign mem_rsp_tag = mem_rsp_valid ? tag_reg[LAT-1] : ~tag_reg[LAT-1];
	assign mem_rsp_data = mem_rsp_valid ? rsp_word : ~rsp_word;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= {pend_reg[LAT-2:0], mem_cmd_valid & ~mem_cmd_write};
			tag_reg[0] <= mem_cmd_tag;
			for (int i = 1; i < LAT; i++) begin
				tag_reg[i] <= tag_reg[i-1];
			end
		end
	end
endmodule // mrs_mem_model

// ===== dv/tb_top.sv
// Self-checking bench for the memory request scheduler
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top;
	import mrs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [15:0] addr; logic crit; logic drop;} mrs_row_type;
	mrs_row_type rows [5] = '{'{16'h0010, 1, 0}, '{16'h2004, 0, 0}, '{16'h3000, 0, 1},
		'{16'h0FFF, 0, 0}, '{16'h1000, 1, 1}};
	logic sys_clk = 0, rst_n = 0, stall = 0, err_clear = 0, cancel_valid = 0, merge_done = 0;
	logic [2:0] req_partial = 0;
	logic pb_retry, merge_done_ack, merge_req_valid;
	logic [2:0] req_valid = 0, req_write = 0, req_crit = 0, req_ready;
	logic [15:0] req_addr [3] = '{default: 0};
	logic [3:0] req_tag [3] = '{default: 0};
	logic [31:0] req_data [3] = '{default: 0};
	logic [15:0] range_base [2] = '{16'h0000, 16'h2000};
	logic [15:0] range_limit [2] = '{16'h0FFF, 16'h2FFF};
	logic [3:0] interleave_way_field [2] = '{4'hF, 4'h1};
	logic [3:0] cancel_tag = 0, mem_rsp_tag, fwd_tag, mem_cmd_tag, rd_rsp_tag;
	logic mem_cmd_ready, mem_rsp_valid, priority_bus_request_pin_n, block_next_request_pin_n;
	logic first_error_status_illegal, miss_notify, read_drop, fwd_valid;
	logic mem_cmd_valid, mem_cmd_write, mem_cmd_crit_first, rd_rsp_valid;
	logic [15:0] mem_cmd_addr;
	logic [31:0] mem_rsp_data, fwd_data, rd_rsp_data, mem_cmd_data;
	int fails = 0, total_checks = 0, cyc = 0, c0, n;
	always #50 sys_clk = ~sys_clk;
	always @(negedge sys_clk) cyc++;
	mrs_top DUT (.sys_clk, .rst_n, .req_valid, .req_write, .req_partial, .req_crit, .req_addr,
		.req_tag, .req_data, .req_ready, .pb_retry, .range_base, .range_limit, .interleave_way_field,
		.min_write_burst_enable(1'b0), .err_clear, .cancel_valid, .cancel_tag, .res_conflict(4'h0),
		.mem_cmd_ready, .mem_rsp_valid, .mem_rsp_tag, .mem_rsp_data, .merge_done,
		.merge_data(32'h0), .merge_done_ack, .merge_req_valid, .merge_req_addr(),
		.priority_bus_request_pin_n, .block_next_request_pin_n, .first_error_status_illegal,
		.miss_notify, .read_drop, .fwd_valid, .fwd_tag, .fwd_data, .mem_cmd_valid, .mem_cmd_write,
		.mem_cmd_crit_first, .mem_cmd_addr, .mem_cmd_tag, .mem_cmd_data, .rd_rsp_valid,
		.rd_rsp_tag, .rd_rsp_data);
	mrs_mem_model MEM (.sys_clk, .rst_n, .stall, .mem_cmd_valid, .mem_cmd_write, .mem_cmd_tag,
		.mem_cmd_ready, .mem_rsp_valid, .mem_rsp_tag, .mem_rsp_data);
	task automatic report_and_stop();
		if (fails == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Entered just after a rising edge; returns on the edge that took the request
	task automatic req(input int s, input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [3:0] t, input logic c);
		int k;
		k = 0;
		req_valid[s] <= 1'b1;
		req_write[s] <= w;
		req_addr[s] <= a;
		req_data[s] <= d;
		req_tag[s] <= t;
		req_crit[s] <= c;
		@(negedge sys_clk);
		while (req_ready[s] !== 1'b1 && k < 200) begin
			@(negedge sys_clk);
			k++;
		end
		if (k == 200) fails++;
		@(posedge sys_clk);
		req_valid[s] <= 1'b0;
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		`CHK("prio pin", 1'b1, priority_bus_request_pin_n)
		`CHK("block pin", 1'b1, block_next_request_pin_n)
		`CHK("illegal", 1'b0, first_error_status_illegal)
		@(posedge sys_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge sys_clk);
			req(2, 0, rows[i].addr, 0, 4'(i), rows[i].crit);
			@(negedge sys_clk);
			`CHK("read_drop", rows[i].drop, read_drop)
			`CHK("cmd valid", !rows[i].drop, mem_cmd_valid)
			if (!rows[i].drop) `CHK("cmd addr", rows[i].addr, mem_cmd_addr)
			if (!rows[i].drop) `CHK("crit", rows[i].crit, mem_cmd_crit_first)
		end
		@(posedge sys_clk);
		req_valid <= 3'b111;
		@(negedge sys_clk);
		`CHK("grant pb", 3'b001, req_ready)
		@(posedge sys_clk);
		req_valid[0] <= 1'b0;
		@(negedge sys_clk);
		`CHK("grant remote", 3'b010, req_ready)
		@(posedge sys_clk);
		req_valid[1] <= 1'b0;
		@(negedge sys_clk);
		`CHK("grant local", 3'b100, req_ready)
		@(posedge sys_clk);
		req_valid[2] <= 1'b0;
		repeat (8) @(posedge sys_clk);
		req(2, 0, 16'h0020, 0, 4'h9, 1);
		cancel_valid <= 1'b1;
		cancel_tag <= 4'h9;
		@(posedge sys_clk);
		cancel_valid <= 1'b0;
		n = 0;
		repeat (10) @(negedge sys_clk) if (rd_rsp_valid === 1'b1) n++;
		`CHK("late cancel rsp", 0, n)
		@(posedge sys_clk);
		req(2, 0, 16'h0030, 0, 4'h6, 1);
		n = 0;
		while (rd_rsp_valid !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("rsp tag", 4'h6, rd_rsp_tag)
		`CHK("rsp data", 32'hD0000006, rd_rsp_data)
		// Stalled memory keeps writes posted for the forwarding and fill cases
		@(posedge sys_clk);
		stall <= 1'b1;
		req(2, 1, 16'h0040, 32'h1234ABCD, 4'h1, 0);
		@(posedge sys_clk);
		req(2, 1, 16'h0040, 32'h5555AAAA, 4'h2, 0);
		@(posedge sys_clk);
		req(2, 0, 16'h0040, 0, 4'h3, 0);
		c0 = cyc;
		@(negedge sys_clk);
		`CHK("fwd valid", 1'b1, fwd_valid)
		`CHK("fwd tag", 4'h3, fwd_tag)
		`CHK("fwd data", 32'h5555AAAA, fwd_data)
		@(posedge sys_clk);
		req(2, 0, 16'h0040, 0, 4'h4, 0);
		`CHK("copy gap", 1'b1, (cyc - c0) >= 8)
		@(posedge sys_clk);
		req(1, 1, 16'h3000, 0, 4'h5, 0);
		repeat (2) @(negedge sys_clk);
		`CHK("illegal", 1'b1, first_error_status_illegal)
		@(posedge sys_clk);
		req(0, 1, 16'h3000, 0, 4'h7, 0);
		@(negedge sys_clk);
		`CHK("miss notify", 1'b1, miss_notify)
		@(posedge sys_clk);
		err_clear <= 1'b1;
		@(posedge sys_clk);
		err_clear <= 1'b0;
		@(negedge sys_clk);
		`CHK("illegal clear", 1'b0, first_error_status_illegal)
		for (int i = 0; i < 58; i++) begin
			@(posedge sys_clk);
			req(2, 1, 16'(16'h0100 + i), 32'(i), 4'h8, 0);
		end
		repeat (2) @(negedge sys_clk);
		`CHK("block at 60", 1'b0, block_next_request_pin_n)
		@(posedge sys_clk);
		stall <= 1'b0;
		n = 0;
		// Oldest posting leaves first, with its own data
		while (mem_cmd_valid !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("drain write", 1'b1, mem_cmd_write)
		`CHK("drain addr", 16'h0040, mem_cmd_addr)
		`CHK("drain data", 32'h1234ABCD, mem_cmd_data)
		n = 0;
		while (block_next_request_pin_n !== 1'b1 && n < 300) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("block release", 1'b1, block_next_request_pin_n)
		@(posedge sys_clk);
		req_partial[2] <= 1'b1;
		req(2, 1, 16'h0050, 0, 4'h1, 0);
		req_partial[2] <= 1'b0;
		@(negedge sys_clk);
		`CHK("merge req", 1'b1, merge_req_valid)
		@(posedge sys_clk);
		req_valid[0] <= 1'b1;
		req_write[0] <= 1'b0;
		req_addr[0] <= 16'h0050;
		@(negedge sys_clk);
		`CHK("merge retry", 1'b1, pb_retry)
		@(posedge sys_clk);
		req_valid[0] <= 1'b0;
		merge_done <= 1'b1;
		@(negedge sys_clk);
		`CHK("merge ack", 1'b1, merge_done_ack)
		@(posedge sys_clk);
		merge_done <= 1'b0;
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		report_and_stop();
	end
endmodule // tb_top
